// ### smb_target_regs.svh
// constants for the two-wire management target: addresses, strap codes, timing
`ifndef SMB_TARGET_REGS_SVH
`define SMB_TARGET_REGS_SVH

// core clock rate in kHz
`define SMB_CLK_KHZ 25000
// clock-low timeout (least time) and stretch limit (longest time), in ms
`define SMB_TIMEOUT_MS 25
`define SMB_STRETCH_MS 1
// core cycles kept in hand for the crossing back to the link
`define SMB_CDC_MARGIN 16

// address bytes, bit 0 is the direction bit; the alert response address is given as 7 bits
`define SMB_CTRL_BASE 8'hb0
`define SMB_EE_OFFSET 8'h10
`define SMB_ARA_ADDR7 7'h19
`define SMB_OPEN_IDX 2'h3

// strap code: bit 3 open pin, bit 2 register group, bits 1:0 address index
`define SMB_STRAP_OPEN_BIT 3
`define SMB_STRAP_REG_BIT 2

// transfer sizes
`define SMB_EE_DEPTH 256
`define SMB_BLOCK_MAX 8'hff
`define SMB_REG_WR_BYTES 8'h03
`define SMB_REG_RD_BYTES 8'h02
`define SMB_FILL_BYTE 8'hff

`endif

// ### smb_target_pkg.sv
// types shared by the two-wire management target
package smb_target_pkg;

  typedef enum logic {PROTO_CMD, PROTO_REG} proto_type;

  typedef enum logic [1:0] {T_NONE, T_CTRL, T_EE, T_ARA} target_type;

  typedef enum logic [1:0] {EV_FIRST, EV_BYTE, EV_END, EV_RD} ev_kind_type;

  // event handed from the link domain to the core domain
  typedef struct packed {
    ev_kind_type kind;
    logic [7:0] data;
    logic flag;
  } link_ev_type;

endpackage : smb_target_pkg

// ### cdc_sync.sv
// two-flop synchroniser with a change pulse behind it
`timescale 1ns/100ps
`default_nettype none
module cdc_sync (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // level from another domain
  input wire logic d,
  // synchronised level and one-cycle change pulse
  output logic q,
  output logic chg
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // only the second flop reads the first
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign q = sync_ff;
  assign chg = sync_ff ^ last_ff;
endmodule : cdc_sync
`default_nettype wire

// ### smb_target.sv
// two-wire management target with strap selection, alert and user eeprom
// Operation
// (R01) target only; never starts, drives start or arbitrates.
// (R02) host clocks the bus at no more than 100 kbps.
// (R03) a clock stretch is released within 1 ms.
// (R04) clock low over 25 ms is a timeout; ready again within 10 ms.
// (R05) start and stop are seen anywhere and restart or abort the engine.
// (R06) alert output low while any shutdown or warning event is present.
// (R07) read at alert response address 0x19 returns the status register.
// (R08) protocol and controller address come from the strap resistor.
// (R09) strap sampled once after reset; later changes are ignored.
// (R10) open strap gives register protocol, controller 0xB6, eeprom 0xA6.
// (R11) low four codes command protocol, high four register; addresses 0xB0 to 0xB6.
// (R12) eeprom address is controller address minus 0x10.
// (R13) eeprom address is derived whenever the controller address is set.
// (R14) address bytes carry the direction in bit 0.
// (R15) eeprom writes blocked while protected; protected after reset, cleared by command.
// (R16) eeprom holds 256 user bytes.
// (R17) host writes eeprom as address, location, data, stop.
// (R18) host waits 5 ms after an eeprom write stop before next start.
// (R19) eeprom read: location write, repeated start, read returns that byte.
// (R20) host prefers single-byte eeprom transfers.
// (R21) register protocol uses one access form by register number, no error byte.
// (R22) register protocol writes are word writes only; byte writes refused.
// (R23) register protocol reads are word reads only.
// (R24) command protocol also takes block transfers up to 255 bytes.
// (R25) only controller, eeprom and alert response addresses are acknowledged.
// (R26) on timeout both lines are released and the engine goes idle.
`timescale 1ns/100ps
`default_nettype none
`include "smb_target_regs.svh"
module smb_target
  import smb_target_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SMB_TIMEOUT_MS * `SMB_CLK_KHZ + 1,
  parameter int STRETCH_CYC = `SMB_STRETCH_MS * `SMB_CLK_KHZ,
  parameter int EE_DEPTH = `SMB_EE_DEPTH,
  parameter int EV_W = 8
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic link_clk,
  // bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // strap and alert
  input wire logic [3:0] strap_resistor_code,
  input wire logic [EV_W-1:0] shutdown_events,
  input wire logic [EV_W-1:0] warning_events,
  input wire logic [7:0] status_reg,
  output logic alert_out_n,
  // controller side
  output logic proto_is_reg,
  output logic rx_valid,
  output logic rx_first,
  output logic [7:0] rx_byte,
  output logic xfer_end,
  output logic xfer_good,
  output logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic wp_clear
);
  localparam int LW = $clog2(EE_DEPTH);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam int STRETCH_LIM = STRETCH_CYC - `SMB_CDC_MARGIN;
  localparam int SW = $clog2(STRETCH_CYC + 1);

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK,
                            ST_RD_WAIT, ST_RD_BYTE, ST_RD_ACK} eng_state_type;

  // ---------------- core domain ----------------
  logic [3:0] strap_q;
  logic scl_c;
  logic ev_new;
  logic [1:0] settle_ff;
  logic strap_taken_ff;
  proto_type proto_ff;
  logic [7:0] ctrl_addr_ff;
  logic [7:0] ee_addr_ff;
  logic alert_n_ff;
  logic [TW-1:0] low_cnt_ff;
  logic to_tgl_ff;
  logic wp_tgl_ff;
  logic wait_busy_ff;
  logic [SW-1:0] wait_cnt_ff;
  logic [7:0] ans_data_ff;
  logic ans_tgl_ff;
  logic rx_valid_ff, rx_first_ff, xfer_end_ff, xfer_good_ff, rd_req_ff;
  logic [7:0] rx_byte_ff;
  // ---------------- link domain ----------------
  logic link_rst, scl_l, sda_l, cfg_ok_l, ans_chg, to_chg, wp_chg;
  eng_state_type state_ff, nxt_state;
  logic [3:0] bitcnt_ff, nxt_bitcnt;
  logic [7:0] shift_ff, nxt_shift;
  logic rw_ff, nxt_rw, acc_ff, nxt_acc, nack_ff, nxt_nack;
  target_type tgt_ff, nxt_tgt;
  logic sda_oe_ff, nxt_sda_oe, scl_oe_ff, nxt_scl_oe;
  logic scl_prev_ff, sda_prev_ff;
  logic [7:0] wr_cnt_ff, nxt_wr_cnt, rd_cnt_ff, nxt_rd_cnt;
  logic [LW-1:0] ee_loc_ff, nxt_ee_loc;
  logic [7:0] mem_ff [EE_DEPTH];
  logic wp_ff;
  link_ev_type ev_ff, nxt_ev;
  logic ev_tgl_ff, nxt_ev_tgl;
  logic go_read;

  // strap, clock and event synchronisers into the core domain
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strap
      cdc_sync u_strap (.clk(core_clk), .rst(reset), .d(strap_resistor_code[gi]),
                        .q(strap_q[gi]), .chg());
    end
  endgenerate
  cdc_sync u_scl_c (.clk(core_clk), .rst(reset), .d(scl_in), .q(scl_c), .chg());
  cdc_sync u_ev (.clk(core_clk), .rst(reset), .d(ev_tgl_ff), .q(), .chg(ev_new));

  // strap decode
  wire strap_open = strap_q[`SMB_STRAP_OPEN_BIT];
  wire [1:0] strap_idx = strap_open ? `SMB_OPEN_IDX : strap_q[1:0];
  wire [7:0] nxt_ctrl_addr = `SMB_CTRL_BASE | {5'h00, strap_idx, 1'b0};
  wire proto_pick_reg = strap_open | strap_q[`SMB_STRAP_REG_BIT];
  wire strap_catch = !strap_taken_ff && (settle_ff == 2'h3);

  // strap captured once, a few cycles after reset release
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settle_ff <= 2'h0;
      strap_taken_ff <= 1'b0;
      proto_ff <= PROTO_REG;
      ctrl_addr_ff <= 8'h00;
      ee_addr_ff <= 8'h00;
    end else begin
      if (settle_ff != 2'h3) settle_ff <= settle_ff + 2'h1;
      if (strap_catch) begin // R08 R09
        strap_taken_ff <= 1'b1;
        proto_ff <= proto_pick_reg ? PROTO_REG : PROTO_CMD; // R10 R11
        ctrl_addr_ff <= nxt_ctrl_addr; // R11
        ee_addr_ff <= nxt_ctrl_addr - `SMB_EE_OFFSET; // R12 R13
      end
    end
  end

  // alert follows the or of both event groups
  always_ff @(posedge core_clk) begin
    if (reset) alert_n_ff <= 1'b1;
    else alert_n_ff <= !(|shutdown_events || |warning_events); // R06
  end

  // clock-low timeout counter
  wire to_hit = !scl_c && (low_cnt_ff == TW'(TIMEOUT_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (reset) begin
      low_cnt_ff <= '0;
      to_tgl_ff <= 1'b0;
    end else begin
      if (scl_c) low_cnt_ff <= '0;
      else if (low_cnt_ff != TW'(TIMEOUT_CYC)) low_cnt_ff <= low_cnt_ff + 1'b1;
      if (to_hit) to_tgl_ff <= !to_tgl_ff; // R04
    end
  end

  // write-protect release request toward the link
  always_ff @(posedge core_clk) begin
    if (reset) wp_tgl_ff <= 1'b0;
    else if (wp_clear) wp_tgl_ff <= !wp_tgl_ff; // R15
  end

  // event decode and read answers
  wire ev_rd = ev_new && (ev_ff.kind == EV_RD);
  wire wait_expire = wait_busy_ff && (wait_cnt_ff == SW'(STRETCH_LIM));
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_busy_ff <= 1'b0;
      wait_cnt_ff <= '0;
      ans_data_ff <= 8'h00;
      ans_tgl_ff <= 1'b0;
    end else if (ev_rd && ev_ff.flag) begin
      ans_data_ff <= status_reg; // R07
      ans_tgl_ff <= !ans_tgl_ff;
    end else if (ev_rd) begin
      wait_busy_ff <= 1'b1;
      wait_cnt_ff <= '0;
    end else if (wait_busy_ff && (rd_valid || wait_expire || to_hit)) begin
      wait_busy_ff <= 1'b0;
      ans_data_ff <= rd_valid ? rd_data : `SMB_FILL_BYTE; // R03
      ans_tgl_ff <= !ans_tgl_ff;
    end else if (wait_busy_ff) begin
      wait_cnt_ff <= wait_cnt_ff + 1'b1;
    end
  end

  // controller-side strobes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_valid_ff <= 1'b0;
      rx_first_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
      xfer_end_ff <= 1'b0;
      xfer_good_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else begin
      rx_valid_ff <= ev_new && (ev_ff.kind == EV_FIRST || ev_ff.kind == EV_BYTE);
      xfer_end_ff <= ev_new && (ev_ff.kind == EV_END);
      rd_req_ff <= ev_rd && !ev_ff.flag;
      if (ev_new) begin
        rx_first_ff <= (ev_ff.kind == EV_FIRST);
        rx_byte_ff <= ev_ff.data;
        xfer_good_ff <= ev_ff.flag;
      end
    end
  end

  assign alert_out_n = alert_n_ff;
  assign proto_is_reg = (proto_ff == PROTO_REG);
  assign rx_valid = rx_valid_ff;
  assign rx_first = rx_first_ff;
  assign rx_byte = rx_byte_ff;
  assign xfer_end = xfer_end_ff;
  assign xfer_good = xfer_good_ff;
  assign rd_req = rd_req_ff;

  // synchronisers into the link domain
  cdc_sync u_rst_l (.clk(link_clk), .rst(1'b0), .d(reset), .q(link_rst), .chg());
  cdc_sync u_scl_l (.clk(link_clk), .rst(link_rst), .d(scl_in), .q(scl_l), .chg());
  cdc_sync u_sda_l (.clk(link_clk), .rst(link_rst), .d(sda_in), .q(sda_l), .chg());
  cdc_sync u_cfg_l (.clk(link_clk), .rst(link_rst), .d(strap_taken_ff), .q(cfg_ok_l), .chg());
  cdc_sync u_ans_l (.clk(link_clk), .rst(link_rst), .d(ans_tgl_ff), .q(), .chg(ans_chg));
  cdc_sync u_to_l (.clk(link_clk), .rst(link_rst), .d(to_tgl_ff), .q(), .chg(to_chg));
  cdc_sync u_wp_l (.clk(link_clk), .rst(link_rst), .d(wp_tgl_ff), .q(), .chg(wp_chg));

  // bus conditions and address match
  wire scl_rise = scl_l && !scl_prev_ff;
  wire scl_fall = !scl_l && scl_prev_ff;
  wire start_det = scl_l && scl_prev_ff && sda_prev_ff && !sda_l; // R05
  wire stop_det = scl_l && scl_prev_ff && !sda_prev_ff && sda_l; // R05
  wire hit_ctrl = cfg_ok_l && (shift_ff[7:1] == ctrl_addr_ff[7:1]); // R14
  wire hit_ee = cfg_ok_l && (shift_ff[7:1] == ee_addr_ff[7:1]);
  wire hit_ara = cfg_ok_l && (shift_ff[7:1] == `SMB_ARA_ADDR7) && shift_ff[0]; // R07
  wire target_type tgt_hit = hit_ctrl ? T_CTRL : hit_ee ? T_EE : hit_ara ? T_ARA : T_NONE;
  wire [8:0] tot = {1'b0, wr_cnt_ff} + {1'b0, rd_cnt_ff};
  wire is_reg = (proto_ff == PROTO_REG);
  wire wr_accept = (tgt_ff == T_EE) || (is_reg ? (wr_cnt_ff < `SMB_REG_WR_BYTES) // R22
                                               : (tot < {1'b0, `SMB_BLOCK_MAX})); // R24
  wire ctrl_fill = (tgt_ff == T_CTRL) && (is_reg ? (rd_cnt_ff >= `SMB_REG_RD_BYTES) // R23
                                                 : (tot >= {1'b0, `SMB_BLOCK_MAX}));
  wire ara_fill = (tgt_ff == T_ARA) && (rd_cnt_ff != 8'h00);
  wire rd_local = (tgt_ff == T_EE) || ctrl_fill || ara_fill;
  wire [7:0] local_byte = (tgt_ff == T_EE) ? mem_ff[ee_loc_ff] : `SMB_FILL_BYTE;
  wire xfer_ok = !is_reg || (wr_cnt_ff == `SMB_REG_WR_BYTES && rd_cnt_ff == 8'h00)
                 || (wr_cnt_ff == 8'h01 && rd_cnt_ff == `SMB_REG_RD_BYTES); // R21 R22 R23
  wire byte_done = scl_fall && (bitcnt_ff == 4'h8);
  wire ee_wr_try = (state_ff == ST_WR_BYTE) && byte_done && (tgt_ff == T_EE)
                   && (wr_cnt_ff != 8'h00) && !to_chg && !stop_det && !start_det;
  wire ee_we = ee_wr_try && !wp_ff; // R15

  // protocol engine, next state
  always_comb begin
    go_read = 1'b0;
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_rw = rw_ff;
    nxt_acc = acc_ff;
    nxt_nack = nack_ff;
    nxt_tgt = tgt_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_wr_cnt = wr_cnt_ff;
    nxt_rd_cnt = rd_cnt_ff;
    nxt_ee_loc = ee_loc_ff;
    nxt_ev = ev_ff;
    nxt_ev_tgl = ev_tgl_ff;
    if (to_chg) begin // R26
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_wr_cnt = 8'h00;
      nxt_rd_cnt = 8'h00;
    end else if (stop_det) begin
      if (tgt_ff == T_CTRL && tot != 9'h000) begin
        nxt_ev = '{kind: EV_END, data: 8'h00, flag: xfer_ok};
        nxt_ev_tgl = !ev_tgl_ff;
      end
      nxt_state = ST_IDLE;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
      nxt_wr_cnt = 8'h00;
      nxt_rd_cnt = 8'h00;
    end else if (start_det) begin // R05
      nxt_state = ST_ADDR;
      nxt_bitcnt = 4'h0;
      nxt_sda_oe = 1'b0;
      nxt_scl_oe = 1'b0;
    end else begin
      if (scl_rise && bitcnt_ff != 4'h8) begin
        if (state_ff == ST_ADDR || state_ff == ST_WR_BYTE) begin
          nxt_shift = {shift_ff[6:0], sda_l};
          nxt_bitcnt = bitcnt_ff + 4'h1;
        end else if (state_ff == ST_RD_BYTE) begin
          nxt_bitcnt = bitcnt_ff + 4'h1;
        end
      end
      if (scl_rise && state_ff == ST_RD_ACK) nxt_nack = sda_l;
      if (scl_fall) begin
        case (state_ff)
          ST_ADDR: if (bitcnt_ff == 4'h8) begin
            nxt_tgt = tgt_hit;
            nxt_rw = shift_ff[0];
            nxt_sda_oe = (tgt_hit != T_NONE); // R25
            nxt_state = (tgt_hit != T_NONE) ? ST_ADDR_ACK : ST_IDLE;
          end
          ST_ADDR_ACK: begin
            nxt_sda_oe = 1'b0;
            nxt_bitcnt = 4'h0;
            if (rw_ff) go_read = 1'b1;
            else nxt_state = ST_WR_BYTE;
          end
          ST_WR_BYTE: if (bitcnt_ff == 4'h8) begin
            nxt_acc = wr_accept;
            nxt_sda_oe = wr_accept;
            nxt_state = ST_WR_ACK;
            if (wr_accept) begin
              nxt_wr_cnt = wr_cnt_ff + 8'h01;
              if (tgt_ff == T_EE) begin // R17 R19
                nxt_ee_loc = (wr_cnt_ff == 8'h00) ? LW'(shift_ff) : ee_loc_ff + 1'b1;
              end else begin
                nxt_ev = '{kind: (wr_cnt_ff == 8'h00) ? EV_FIRST : EV_BYTE,
                           data: shift_ff, flag: 1'b0};
                nxt_ev_tgl = !ev_tgl_ff;
              end
            end
          end
          ST_WR_ACK: begin
            nxt_sda_oe = 1'b0;
            nxt_bitcnt = 4'h0;
            nxt_state = acc_ff ? ST_WR_BYTE : ST_IDLE;
          end
          ST_RD_BYTE: begin
            if (bitcnt_ff == 4'h8) begin
              nxt_sda_oe = 1'b0;
              nxt_state = ST_RD_ACK;
            end else begin
              nxt_sda_oe = !shift_ff[3'(4'h7 - bitcnt_ff)];
            end
          end
          ST_RD_ACK: begin
            if (nack_ff) nxt_state = ST_IDLE;
            else go_read = 1'b1;
          end
          default: ;
        endcase
      end
      // answer from the core ends the stretch
      if (state_ff == ST_RD_WAIT && ans_chg) begin
        nxt_shift = ans_data_ff;
        nxt_sda_oe = !ans_data_ff[7];
        nxt_scl_oe = 1'b0; // R03
        nxt_bitcnt = 4'h0;
        nxt_rd_cnt = rd_cnt_ff + 8'h01;
        nxt_state = ST_RD_BYTE;
      end
    end
    // start of a data byte toward the host
    if (go_read) begin
      nxt_bitcnt = 4'h0;
      if (rd_local) begin // R19
        nxt_shift = local_byte;
        nxt_sda_oe = !local_byte[7];
        nxt_state = ST_RD_BYTE;
        if (rd_cnt_ff != 8'hff) nxt_rd_cnt = rd_cnt_ff + 8'h01;
        if (tgt_ff == T_EE) nxt_ee_loc = ee_loc_ff + 1'b1;
      end else begin
        nxt_ev = '{kind: EV_RD, data: 8'h00, flag: (tgt_ff == T_ARA)};
        nxt_ev_tgl = !ev_tgl_ff;
        nxt_scl_oe = 1'b1;
        nxt_state = ST_RD_WAIT;
      end
    end
  end

  // protocol engine registers
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_ff <= ST_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      acc_ff <= 1'b0;
      nack_ff <= 1'b1;
      tgt_ff <= T_NONE;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      wr_cnt_ff <= 8'h00;
      rd_cnt_ff <= 8'h00;
      ee_loc_ff <= '0;
      ev_ff <= '0;
      ev_tgl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      rw_ff <= nxt_rw;
      acc_ff <= nxt_acc;
      nack_ff <= nxt_nack;
      tgt_ff <= nxt_tgt;
      sda_oe_ff <= nxt_sda_oe;
      scl_oe_ff <= nxt_scl_oe;
      scl_prev_ff <= scl_l;
      sda_prev_ff <= sda_l;
      wr_cnt_ff <= nxt_wr_cnt;
      rd_cnt_ff <= nxt_rd_cnt;
      ee_loc_ff <= nxt_ee_loc;
      ev_ff <= nxt_ev;
      ev_tgl_ff <= nxt_ev_tgl;
    end
  end

  // user eeprom storage and its write protect
  always_ff @(posedge link_clk) begin
    if (link_rst) mem_ff <= '{default: `SMB_FILL_BYTE}; // erased contents, never unknown
    else if (ee_we) mem_ff[ee_loc_ff] <= shift_ff; // R16
  end
  always_ff @(posedge link_clk) begin
    if (link_rst) wp_ff <= 1'b1; // R15
    else if (wp_chg) wp_ff <= 1'b0;
  end

  // open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff; // R01

  // checks in the link domain
  chk_sda_low_scl: assert property (@(posedge link_clk) disable iff (link_rst) // R01
    $rose(sda_oe_ff) |-> !$past(scl_l)) else $error("sda pulled while scl high");
  chk_start_restart: assert property (@(posedge link_clk) disable iff (link_rst) // R05
    (start_det && !to_chg) |=> (state_ff == ST_ADDR) && (bitcnt_ff == 4'h0) && !scl_oe_ff)
    else $error("start did not restart engine");
  chk_timeout_idle: assert property (@(posedge link_clk) disable iff (link_rst) // R26
    to_chg |=> (state_ff == ST_IDLE) && !sda_oe_ff && !scl_oe_ff)
    else $error("timeout left engine busy");
  chk_foreign_nack: assert property (@(posedge link_clk) disable iff (link_rst) // R25
    (state_ff == ST_ADDR && byte_done && tgt_hit == T_NONE && !start_det && !stop_det
     && !to_chg) |=> (state_ff == ST_IDLE) && !sda_oe_ff)
    else $error("foreign address acknowledged");
  chk_word_only: assert property (@(posedge link_clk) disable iff (link_rst) // R22
    (state_ff == ST_WR_BYTE && byte_done && tgt_ff == T_CTRL && is_reg && !to_chg
     && wr_cnt_ff >= `SMB_REG_WR_BYTES && !start_det && !stop_det) |=> !sda_oe_ff)
    else $error("extra register byte acknowledged");
  chk_wp_reset: assert property (@(posedge link_clk) disable iff (link_rst) // R15
    $fell(link_rst) |-> wp_ff) else $error("protect not set after reset");
  chk_wp_blocks: assert property (@(posedge link_clk) disable iff (link_rst) // R15
    (ee_wr_try && wp_ff) |=> mem_ff[$past(ee_loc_ff)] == $past(mem_ff[ee_loc_ff]))
    else $error("protected eeprom byte changed");
  // checks in the core domain
  chk_stretch_end: assert property (@(posedge core_clk) disable iff (reset) // R03
    wait_expire |=> !wait_busy_ff && $changed(ans_tgl_ff) && ans_data_ff == `SMB_FILL_BYTE)
    else $error("stretch not ended at limit");
  chk_timeout_fire: assert property (@(posedge core_clk) disable iff (reset) // R04
    to_hit |=> $changed(to_tgl_ff)) else $error("timeout not signalled");
  chk_alert_or: assert property (@(posedge core_clk) disable iff (reset) // R06
    ##1 (alert_out_n == !$past(|shutdown_events || |warning_events)))
    else $error("alert not the or of events");
  chk_ara_status: assert property (@(posedge core_clk) disable iff (reset) // R07
    (ev_rd && ev_ff.flag) |=> $changed(ans_tgl_ff) && ans_data_ff == $past(status_reg))
    else $error("alert response not status");
  chk_strap_held: assert property (@(posedge core_clk) disable iff (reset) // R09
    strap_taken_ff |=> $stable(ctrl_addr_ff) && $stable(proto_ff))
    else $error("strap result changed");
  chk_ee_offset: assert property (@(posedge core_clk) disable iff (reset) // R12
    strap_taken_ff |-> (8'(ee_addr_ff + `SMB_EE_OFFSET) == ctrl_addr_ff))
    else $error("eeprom address offset wrong");
  cov_ee_write: cover property (@(posedge link_clk) disable iff (link_rst) ee_we);
  cov_ara_read: cover property (@(posedge core_clk) disable iff (reset) ev_rd && ev_ff.flag);
  cov_timeout: cover property (@(posedge core_clk) disable iff (reset) to_hit);
  cov_ctrl_end: cover property (@(posedge core_clk) disable iff (reset) xfer_end && xfer_good);
endmodule : smb_target
`default_nettype wire

// ### smb_host.sv
// bus host model: open drain pulls, start, stop and nine-bit slots
`timescale 1ns/100ps
`default_nettype none
module smb_host (
  // device pulls
  input wire logic scl_oe,
  input wire logic sda_oe,
  // resolved wire levels
  output logic scl_w,
  output logic sda_w
);
  localparam int HALF = 5000;
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  int stretch_err = 0;
  // pull-ups win unless a party pulls
  assign scl_w = !(scl_pull | scl_oe);
  assign sda_w = !(sda_pull | sda_oe);
  // release clock, wait out a stretch of up to 1 ms, count a longer one
  task automatic rise;
    int n;
    scl_pull = 1'b0;
    for (n = 0; n < 10000 && !scl_w; n++) #100;
    if (!scl_w) stretch_err++;
    #HALF;
  endtask : rise
  // start or repeated start, host only
  task automatic start;
    sda_pull = 1'b0;
    #HALF;
    rise;
    sda_pull = 1'b1;
    #HALF;
    scl_pull = 1'b1;
  endtask : start
  task automatic stop;
    sda_pull = 1'b1;
    #HALF;
    rise;
    sda_pull = 1'b0;
    #HALF;
  endtask : stop
  // eight bits plus ack slot, msb first
  task automatic xb(input logic [8:0] d, output logic [8:0] r);
    int i;
    for (i = 8; i >= 0; i--) begin
      sda_pull = !d[i];
      #HALF;
      rise;
      r[i] = sda_w;
      scl_pull = 1'b1;
    end
    sda_pull = 1'b0;
  endtask : xb
endmodule : smb_host
`default_nettype wire

// ### testbench.sv
// testbench for the two-wire management target
`timescale 1ns/100ps
`default_nettype none
module testbench import smb_target_pkg::*;;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic scl_w, sda_w, scl_oe, sda_oe, alert_out_n, proto_is_reg, rx_valid, rx_first;
  logic xfer_end, xfer_good, rd_req, rd_valid, wp_clear, good, mute, reg_p, scl_out, sda_out;
  logic [3:0] strap;
  logic [7:0] sd, wn, status, rd_data, rx_byte, ca, ea, cmd, cmd_seen;
  logic [8:0] r;
  int fails = 0;
  int samples_checked = 0;
  int rxn = 0;
  int seed, i;
  // clocks, unrelated phases
  always #20 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;
  smb_host smb_host_i (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_w(scl_w), .sda_w(sda_w));
  smb_target #(.TIMEOUT_CYC(2000), .STRETCH_CYC(400)) smb_target_i (
    .core_clk(core_clk), .reset(reset), .link_clk(link_clk),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe),
    .strap_resistor_code(strap), .shutdown_events(sd), .warning_events(wn),
    .status_reg(status), .alert_out_n(alert_out_n), .proto_is_reg(proto_is_reg),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_byte(rx_byte), .xfer_end(xfer_end),
    .xfer_good(xfer_good), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .wp_clear(wp_clear));
  // read answers next cycle unless muted; byte, command and end monitor
  always @(posedge core_clk) begin
    rd_valid <= rd_req && !mute;
    if (rx_valid) rxn <= rxn + 1;
    if (rx_valid && rx_first) cmd_seen <= rx_byte;
    if (xfer_end) good <= xfer_good;
  end
  function automatic logic [7:0] ctl(input logic [3:0] s);
    return 8'hb0 + {5'h00, (s[3] ? 2'h3 : s[1:0]), 1'b0};
  endfunction : ctl
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one byte out, ack slot compared
  task automatic wb(input logic [7:0] d, input logic a);
    smb_host_i.xb({d, 1'b1}, r);
    chk(r[0], !a);
  endtask : wb
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    seed = 56455;
    strap = 4'($random(seed));
    {sd, wn, rd_valid, wp_clear, good, mute} = '0;
    status = 8'($random(seed));
    rd_data = 8'($random(seed));
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    ca = ctl(strap);
    ea = ca - 8'h10;
    repeat (20) @(posedge core_clk);
    #1 reg_p = strap[3] | strap[2];
    chk(proto_is_reg, reg_p);
    strap = ~strap;
    for (i = 0; i < 4; i++) begin
      sd = 8'($random(seed)) & {8{i[0]}};
      wn = 8'($random(seed)) & {8{i[1]}};
      repeat (2) @(posedge core_clk);
      #1 chk(alert_out_n, !(|sd || |wn));
    end
    smb_host_i.start;
    wb(ca ^ 8'h08, 1'b0);
    smb_host_i.stop;
    rxn = 0;
    smb_host_i.start;
    wb(ca, 1'b1);
    cmd = 8'($random(seed));
    wb(cmd, 1'b1);
    // a fourth byte is refused by the register protocol only
    for (i = 0; i < 3; i++) wb(8'($random(seed)), i < 2 || !reg_p);
    smb_host_i.stop;
    repeat (10) @(posedge core_clk);
    chk(rxn == (reg_p ? 3 : 4), 1'b1);
    chk(good, 1'b1);
    chk(cmd_seen, cmd);
    smb_host_i.start;
    wb(ca, 1'b1);
    wb(8'h01, 1'b1);
    smb_host_i.start;
    wb(ca | 8'h01, 1'b1);
    smb_host_i.xb(9'h1fe, r);
    chk(r[8:1], rd_data);
    // unanswered second byte: stretch ends at its limit with the fill byte
    mute = 1'b1;
    smb_host_i.xb(9'h1ff, r);
    chk(r[8:1], 8'hff);
    mute = 1'b0;
    smb_host_i.stop;
    repeat (10) @(posedge core_clk);
    chk(good, 1'b1);
    smb_host_i.start;
    wb(8'h32, 1'b0);
    smb_host_i.start;
    wb(8'h33, 1'b1);
    smb_host_i.xb(9'h1ff, r);
    chk(r[8:1], status);
    smb_host_i.stop;
    for (i = 0; i < 2; i++) begin
      smb_host_i.start;
      wb(ea, 1'b1);
      wb(8'hff, 1'b1);
      wb(8'h5a, 1'b1);
      smb_host_i.stop;
      #20000; // bus-free gap after an eeprom write, scaled down for run time
      smb_host_i.start;
      wb(ea, 1'b1);
      wb(8'hff, 1'b1);
      smb_host_i.start;
      wb(ea | 8'h01, 1'b1);
      smb_host_i.xb(9'h1ff, r);
      smb_host_i.stop;
      chk(r[8:1] === 8'h5a, i[0]);
      @(posedge core_clk) #1 wp_clear = 1'b1;
      @(posedge core_clk) #1 wp_clear = 1'b0;
    end
    smb_host_i.start;
    wb(ca, 1'b1);
    #100000;
    chk({scl_oe, sda_oe}, 2'b00);
    // engine must be idle now: a further byte gets no acknowledge
    wb(8'h00, 1'b0);
    chk({scl_out, sda_out}, 2'b00);
    smb_host_i.stop;
    smb_host_i.start;
    wb(ca, 1'b1);
    smb_host_i.stop;
    chk(smb_host_i.stretch_err == 0, 1'b1);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
